// ===== inc/rd_port_pkg.sv
package rd_port_pkg;

   // Clock and timing
   localparam int           REF_CLK_MHZ      = 50;
   localparam int           SYS_HALVES       = 2;
   localparam logic [2:0]   HALF_CAP         = 3'h4;

   // Register map (byte addresses)
   localparam logic [7:0]   CTRL_OFFSET      = 8'h00;
   localparam logic [7:0]   STATUS_OFFSET    = 8'h04;

   // Control register fields
   localparam int           MEM_CTRL_LSB     = 0;
   localparam int           IO_CTRL_LSB      = 2;
   localparam int           EXT_CTRL_LSB     = 4;
   localparam int           LANE_MASK_BIT    = 6;
   localparam int           PIN_DIR_LSB      = 7;
   localparam int           CTRL_WIDTH       = 9;
   // Strobe control encoding: bit 0 writes, bit 1 reads
   localparam int           CTRL_WR_BIT      = 0;
   localparam int           CTRL_RD_BIT      = 1;
   localparam logic [8:0]   CTRL_RESET       = 9'h001;

   // Status register fields
   localparam int           ST_BUSY_BIT      = 0;
   localparam int           ST_STRETCH_BIT   = 1;
   localparam int           ST_FAULT_BIT     = 2;

   // Port sizes
   localparam logic [1:0]   PORT_32          = 2'h0;
   localparam logic [1:0]   PORT_16          = 2'h1;
   localparam logic [1:0]   PORT_8           = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ADDR,
      ST_DATA
   } bus_state_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [3:0]  byte_en;
      logic        cache_miss;
      logic        instr_fetch;
      logic        block_read;
      logic [1:0]  port_size;
      logic        big_endian;
      logic [4:0]  datum_total;
   } read_req_t;

endpackage : rd_port_pkg

// ===== rtl/multiplexed_bus_read_port.sv
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// - Bus fault sampled before or with completion ends read, raises exception.
// - Lane enable 1 selects most significant byte of the halfword.
// - Lane enable 0 selects least significant byte of the halfword.
// - Lane enables held inactive on reads when read mask disabled.
// - Final datum flag with read on single reads, after next-to-last capture.
// - Memory strobe pulses low once per datum when enabled for reads.
// - After reset memory strobe is enabled for writes only.
// - I/O strobe asserts on falling edge one clock after latch drops.
// - I/O strobe never asserts in transactions shorter than two clocks.
// - I/O and extended strobe pins are inputs until direction configured.
// - Extended window asserts after latch drops, releases half clock late.
// - Debug pin shows cache miss or uncacheable during address phase.
// - Debug pin shows instruction or data after address phase.
// - Read starts on rising clock edge when idle, nothing higher pending.
// - Higher priority operations postpone the read start.
// - Read begins with read strobe, address and latch pulse together.
// - Release enable stays inactive through the whole address phase.
// - Block flag low for burst; low lines show block start or address.
// - Stretched hold keeps address and delays release by half clock.
// - Turn-around in phase two, or phase one of clock two stretched.
// - Drivers off and release enable together, with latch drop or half clock after it.
// - Address phase puts address 31..4 high and byte strobes low.
// - Outside capture enable makes device capture data; last one ends read.
module multiplexed_bus_read_port
(
   input  wire logic                    REF_CLK,
   input  wire logic                    RESETN,
   input  wire logic [7:0]              REG_ADDR,
   input  wire logic [31:0]             REG_WDATA,
   input  wire logic                    REG_WR,
   input  wire logic                    REG_RD,
   output logic [31:0]                  REG_RDATA,
   input  wire logic                    READ_REQUEST,
   input  wire logic                    HIGHER_PRIO_PENDING,
   input  wire rd_port_pkg::read_req_t  READ_INFO,
   input  wire logic                    STRETCH_HOLD_STRAP,
   output logic [31:0]                  READ_DATA,
   output logic                         READ_DATA_VALID,
   output logic                         READ_DONE,
   output logic                         BUS_FAULT_EXC,
   output logic                         SYS_CLK_OUT,
   output logic                         READ_N,
   output logic                         ALE,
   output logic [31:0]                  AD_OUT,
   output logic                         AD_OE_N,
   input  wire logic [31:0]             AD_IN,
   output logic [3:0]                   LOW_ADDR,
   output logic                         BLOCK_READ_N,
   output logic                         BUS_RELEASE_EN_N,
   output logic [1:0]                   LANE_EN_N,
   output logic                         FINAL_DATUM_N,
   output logic                         MEM_STROBE_N,
   output logic                         IO_STROBE_N_OUT,
   output logic                         IO_STROBE_OE_N,
   input  wire logic                    IO_STROBE_N_IN,
   output logic                         EXT_DATA_N_OUT,
   output logic                         EXT_DATA_OE_N,
   input  wire logic                    EXT_DATA_N_IN,
   output logic                         DEBUG_IND,
   input  wire logic                    READ_CAPTURE_N,
   input  wire logic                    BUS_FAULT_N
);

   rd_port_pkg::bus_state_t state_reg;
   rd_port_pkg::read_req_t  info_reg;
   logic [8:0]              ctrl_reg;
   logic                    system_clock_out_reg;
   logic [2:0]              half_reg;
   logic [4:0]              cnt_reg;
   logic [3:0]              low_addr_reg;
   logic                    cap_pend_reg;
   logic                    fault_pend_reg;
   logic                    fault_seen_reg;
   logic                    ext_tail_reg;
   logic                    stretch_reg;
   logic                    strap_done_reg;
   logic                    start;
   logic                    rise_next;
   logic                    sample_edge;
   logic                    finish;
   logic                    last_cap;
   logic                    rd_mem;
   logic                    rd_io;
   logic                    rd_ext;
   logic [3:0]              unit;
   logic [1:0]              pair;

   // Two REF_CLK edges make one system clock
   assign rise_next   = ~system_clock_out_reg;
   assign sample_edge = rise_next && (state_reg == rd_port_pkg::ST_DATA);
   assign last_cap    = cap_pend_reg && (cnt_reg + 5'h01 >= info_reg.datum_total);
   assign finish      = fault_pend_reg || last_cap;
   assign rd_mem      = ctrl_reg[rd_port_pkg::MEM_CTRL_LSB
                                 + rd_port_pkg::CTRL_RD_BIT];
   assign rd_io       = ctrl_reg[rd_port_pkg::IO_CTRL_LSB
                                 + rd_port_pkg::CTRL_RD_BIT];
   assign rd_ext      = ctrl_reg[rd_port_pkg::EXT_CTRL_LSB
                                 + rd_port_pkg::CTRL_RD_BIT];
   assign start       = READ_REQUEST && !HIGHER_PRIO_PENDING && rise_next
                        && (state_reg == rd_port_pkg::ST_IDLE);

   always_comb
   begin
      case (info_reg.port_size)
         rd_port_pkg::PORT_16: unit = 4'h2;
         rd_port_pkg::PORT_8:  unit = 4'h1;
         default:              unit = 4'h4;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
         system_clock_out_reg <= 1'b0;
      else
         system_clock_out_reg <= ~system_clock_out_reg;
   end
   assign SYS_CLK_OUT = system_clock_out_reg;

   // strap caught once after reset release
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         stretch_reg    <= 1'b0;
         strap_done_reg <= 1'b0;
      end
      else if (!strap_done_reg)
      begin
         stretch_reg    <= STRETCH_HOLD_STRAP;
         strap_done_reg <= 1'b1;
      end
   end

   // Register port
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
         ctrl_reg <= rd_port_pkg::CTRL_RESET;
      else if (REG_WR && REG_ADDR == rd_port_pkg::CTRL_OFFSET)
         ctrl_reg <= REG_WDATA[8:0];
   end

   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
         REG_RDATA <= 32'h0000_0000;
      else if (REG_RD && REG_ADDR == rd_port_pkg::CTRL_OFFSET)
         REG_RDATA <= {23'h00_0000, ctrl_reg};
      else if (REG_RD && REG_ADDR == rd_port_pkg::STATUS_OFFSET)
         REG_RDATA <= {29'h0000_0000, fault_seen_reg, stretch_reg,
                       state_reg != rd_port_pkg::ST_IDLE};
      else
         REG_RDATA <= 32'h0000_0000;
   end

   // Sequencer
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         state_reg <= rd_port_pkg::ST_IDLE;
         half_reg  <= 3'h0;
         info_reg  <= '0;
      end
      else
      begin
         case (state_reg)
            rd_port_pkg::ST_IDLE:
               if (start)
               begin
                  state_reg <= rd_port_pkg::ST_ADDR;
                  half_reg  <= 3'h1;
                  info_reg  <= READ_INFO;
               end
            rd_port_pkg::ST_ADDR:
            begin
               half_reg <= half_reg + 3'h1;
               if (!stretch_reg || half_reg == 3'h2)
                  state_reg <= rd_port_pkg::ST_DATA;
            end
            rd_port_pkg::ST_DATA:
            begin
               if (half_reg != rd_port_pkg::HALF_CAP)
                  half_reg <= half_reg + 3'h1;
               if (finish)
                  state_reg <= rd_port_pkg::ST_IDLE;
            end
            default:
               state_reg <= rd_port_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         cap_pend_reg   <= 1'b0;
         fault_pend_reg <= 1'b0;
      end
      else
      begin
         fault_pend_reg <= sample_edge && !BUS_FAULT_N;
         cap_pend_reg   <= sample_edge && BUS_FAULT_N && !READ_CAPTURE_N;
      end
   end

   // Data capture and counting
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         READ_DATA       <= 32'h0000_0000;
         READ_DATA_VALID <= 1'b0;
         cnt_reg         <= 5'h00;
      end
      else
      begin
         READ_DATA_VALID <= cap_pend_reg;
         if (start)
            cnt_reg <= 5'h00;
         else if (cap_pend_reg)
         begin
            READ_DATA <= AD_IN;
            cnt_reg   <= cnt_reg + 5'h01;
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         BUS_FAULT_EXC  <= 1'b0;
         READ_DONE      <= 1'b0;
         fault_seen_reg <= 1'b0;
      end
      else
      begin
         BUS_FAULT_EXC <= fault_pend_reg;
         READ_DONE     <= finish && (state_reg == rd_port_pkg::ST_DATA);
         if (fault_pend_reg)
            fault_seen_reg <= 1'b1;
         else if (start)
            fault_seen_reg <= 1'b0;
      end
   end

   // read strobe, address and latch pulse
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         READ_N       <= 1'b1;
         ALE          <= 1'b0;
         AD_OUT       <= 32'h0000_0000;
         BLOCK_READ_N <= 1'b1;
      end
      else if (start)
      begin
         READ_N       <= 1'b0;
         ALE          <= 1'b1;
         AD_OUT       <= {READ_INFO.addr[31:4], READ_INFO.byte_en};
         BLOCK_READ_N <= ~READ_INFO.block_read;
      end
      else
      begin
         ALE <= 1'b0;
         if (finish && state_reg == rd_port_pkg::ST_DATA)
         begin
            READ_N       <= 1'b1;
            BLOCK_READ_N <= 1'b1;
         end
      end
   end

   // stretched hold keeps drivers half clock longer
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         AD_OE_N          <= 1'b1;
         BUS_RELEASE_EN_N <= 1'b1;
      end
      else if (start)
      begin
         AD_OE_N          <= 1'b0;
         BUS_RELEASE_EN_N <= 1'b1;
      end
      else if (state_reg == rd_port_pkg::ST_ADDR
               && (!stretch_reg || half_reg == 3'h2))
      begin
         AD_OE_N          <= 1'b1;
         BUS_RELEASE_EN_N <= 1'b0;
      end
      else if (finish && state_reg == rd_port_pkg::ST_DATA)
         BUS_RELEASE_EN_N <= 1'b1;
   end

   // low lines, block start or address
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
         low_addr_reg <= 4'h0;
      else if (start)
      begin
         if (READ_INFO.block_read)
            case (READ_INFO.port_size)
               rd_port_pkg::PORT_16: low_addr_reg <= 4'h0;
               rd_port_pkg::PORT_8:  low_addr_reg <= 4'h0;
               default: low_addr_reg <= {2'h0, READ_INFO.addr[1:0]};
            endcase
         else
            low_addr_reg <= READ_INFO.addr[3:0];
      end
      else if (cap_pend_reg)
         low_addr_reg <= low_addr_reg + unit;
   end
   assign LOW_ADDR = low_addr_reg;

   // miss during address, fetch kind after
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
         DEBUG_IND <= 1'b0;
      else if (start)
         DEBUG_IND <= READ_INFO.cache_miss;
      else if (state_reg == rd_port_pkg::ST_ADDR
               && (!stretch_reg || half_reg == 3'h2))
         DEBUG_IND <= info_reg.instr_fetch;
   end

   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
         FINAL_DATUM_N <= 1'b1;
      else if (start)
         FINAL_DATUM_N <= (READ_INFO.datum_total > 5'h01);
      else if (finish && state_reg == rd_port_pkg::ST_DATA)
         FINAL_DATUM_N <= 1'b1;
      else if (cap_pend_reg && cnt_reg + 5'h02 == info_reg.datum_total)
         FINAL_DATUM_N <= 1'b0;
   end

   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
         MEM_STROBE_N <= 1'b1;
      else if (state_reg != rd_port_pkg::ST_DATA || !rd_mem || finish)
         MEM_STROBE_N <= 1'b1;
      else if (cap_pend_reg)
         MEM_STROBE_N <= 1'b1;
      else if (half_reg >= 3'h2)
         MEM_STROBE_N <= 1'b0;
   end

   // falling edge one clock after latch
   // held off when capture seen early
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
         IO_STROBE_N_OUT <= 1'b1;
      else if (state_reg != rd_port_pkg::ST_DATA || finish)
         IO_STROBE_N_OUT <= 1'b1;
      else if (half_reg == 3'h3 && rd_io && !cap_pend_reg)
         IO_STROBE_N_OUT <= 1'b0;
   end

   // extended window and half clock tail
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         EXT_DATA_N_OUT <= 1'b1;
         ext_tail_reg   <= 1'b0;
      end
      else
      begin
         ext_tail_reg <= finish && state_reg == rd_port_pkg::ST_DATA;
         if (ext_tail_reg || start)
            EXT_DATA_N_OUT <= 1'b1;
         else if (half_reg == 3'h2 && state_reg != rd_port_pkg::ST_IDLE
                  && rd_ext)
            EXT_DATA_N_OUT <= 1'b0;
      end
   end

   assign IO_STROBE_OE_N = ~ctrl_reg[rd_port_pkg::PIN_DIR_LSB];
   assign EXT_DATA_OE_N  = ~ctrl_reg[rd_port_pkg::PIN_DIR_LSB + 1];

   assign pair = low_addr_reg[1] ? info_reg.byte_en[3:2]
                                 : info_reg.byte_en[1:0];
   always_comb
   begin
      LANE_EN_N = 2'b11;
      if (!READ_N && info_reg.port_size == rd_port_pkg::PORT_16
          && ctrl_reg[rd_port_pkg::LANE_MASK_BIT])
      begin
         if (info_reg.big_endian)
            LANE_EN_N = ~{pair[0], pair[1]};
         else
            LANE_EN_N = ~pair;
      end
   end

   property p_ale_half;
      @(posedge REF_CLK) disable iff (!RESETN)
      $rose(ALE) |=> !ALE;
   endproperty
   a_ale_half: assert property (p_ale_half)
      else $error("latch pulse longer than half clock");

   property p_start_rise;
      @(posedge REF_CLK) disable iff (!RESETN)
      $fell(READ_N) |-> system_clock_out_reg && ALE && !AD_OE_N;
   endproperty
   a_start_rise: assert property (p_start_rise)
      else $error("read not started on rising edge");

   property p_release_addr;
      @(posedge REF_CLK) disable iff (!RESETN)
      (ALE || !AD_OE_N) |-> BUS_RELEASE_EN_N;
   endproperty
   a_release_addr: assert property (p_release_addr)
      else $error("release enable active while driving");

   property p_stretch;
      @(posedge REF_CLK) disable iff (!RESETN)
      $fell(ALE) && stretch_reg |-> !AD_OE_N ##1 AD_OE_N && !BUS_RELEASE_EN_N;
   endproperty
   a_stretch: assert property (p_stretch)
      else $error("stretched hold timing wrong");

   property p_fault_end;
      @(posedge REF_CLK) disable iff (!RESETN)
      fault_pend_reg |=> READ_N && BUS_FAULT_EXC && !READ_DATA_VALID;
   endproperty
   a_fault_end: assert property (p_fault_end)
      else $error("fault did not end the read");

   property p_lane_mask;
      @(posedge REF_CLK) disable iff (!RESETN)
      !ctrl_reg[rd_port_pkg::LANE_MASK_BIT] |-> LANE_EN_N == 2'b11;
   endproperty
   a_lane_mask: assert property (p_lane_mask)
      else $error("lane enables active while masked");

   property p_io_time;
      @(posedge REF_CLK) disable iff (!RESETN)
      $fell(IO_STROBE_N_OUT) |-> half_reg == 3'h4 && !system_clock_out_reg && !READ_N;
   endproperty
   a_io_time: assert property (p_io_time)
      else $error("io strobe asserted at wrong time");

   property p_last_single;
      @(posedge REF_CLK) disable iff (!RESETN)
      $fell(READ_N) && info_reg.datum_total == 5'h01 |-> !FINAL_DATUM_N;
   endproperty
   a_last_single: assert property (p_last_single)
      else $error("final flag missing on single read");

   property p_ext_tail;
      @(posedge REF_CLK) disable iff (!RESETN)
      $rose(READ_N) && !EXT_DATA_N_OUT |=> EXT_DATA_N_OUT;
   endproperty
   a_ext_tail: assert property (p_ext_tail)
      else $error("extended window tail wrong");

   property p_mem_pulse;
      @(posedge REF_CLK) disable iff (!RESETN)
      !rd_mem |-> MEM_STROBE_N;
   endproperty
   a_mem_pulse: assert property (p_mem_pulse)
      else $error("memory strobe on while disabled");

   property p_strap_fixed;
      @(posedge REF_CLK) disable iff (!RESETN)
      strap_done_reg |=> $stable(stretch_reg);
   endproperty
   a_strap_fixed: assert property (p_strap_fixed)
      else $error("hold selection changed after reset");

endmodule : multiplexed_bus_read_port

// ===== verification/ext_memory.sv
`timescale 1ns/100ps
module ext_memory
(
   input  wire logic         REF_CLK,
   input  wire logic         RESETN,
   input  wire logic         READ_N,
   input  wire logic         BUS_RELEASE_EN_N,
   input  wire logic [3:0]   LOW_ADDR,
   input  wire logic [7:0]   WAIT_CYCLES,
   input  wire logic         FAULT_MODE,
   output logic [31:0]       AD_IN,
   output logic              READ_CAPTURE_N,
   output logic              BUS_FAULT_N
);
   logic [7:0]  wait_reg;
   logic [31:0] last_reg;
   logic        active;
   logic        ready;

   assign active = !READ_N && !BUS_RELEASE_EN_N;
   assign AD_IN  = active ? {8{LOW_ADDR}} : ~last_reg;
   assign ready  = active && (wait_reg >= WAIT_CYCLES);
   assign READ_CAPTURE_N = !(ready && !FAULT_MODE);
   assign BUS_FAULT_N    = !(ready && FAULT_MODE);

   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
         wait_reg <= 8'h0;
      else if (!active)
         wait_reg <= 8'h0;
      else if (wait_reg != 8'hff)
         wait_reg <= wait_reg + 8'h1;
   end

   always_ff @(posedge REF_CLK)
   begin
      last_reg <= AD_IN;
   end
endmodule : ext_memory

// ===== verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   logic                   clk, rst_n, strap, reg_wr, reg_rd, req, prio;
   logic [7:0]             reg_addr, wait_cyc;
   logic [31:0]            reg_wdata, reg_rdata, ad_out, ad_in, rd_data, r;
   rd_port_pkg::read_req_t info;
   logic [3:0]             low_addr;
   logic [1:0]             lane_n, lanes_seen;
   logic                   fault_mode, read_n, ale, ad_oe_n, rel_n, blk_n;
   logic                   fin_n, mem_n, io_n, io_oe_n, ext_n, ext_oe_n;
   logic                   dbg, cap_n, flt_n, valid, done, exc, sclk;
   logic                   io_seen, ext_seen, exc_seen, prev_mem;
   int                     bad_count, tests_run, nval, nstr;
   wire logic              io_pin, ext_pin;
   logic [3:0]             lbe [3] = '{4'h2, 4'h1, 4'h2};
   logic                   lbig [3] = '{1'b0, 1'b0, 1'b1};
   logic [1:0]             lexp [3] = '{2'h1, 2'h2, 2'h2};

   // Pull-ups on released strobe pins
   assign io_pin  = io_oe_n ? 1'b1 : io_n;
   assign ext_pin = ext_oe_n ? 1'b1 : ext_n;

   multiplexed_bus_read_port u_multiplexed_bus_read_port
   (
      .REF_CLK(clk), .RESETN(rst_n), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_RDATA(reg_rdata), .READ_REQUEST(req), .HIGHER_PRIO_PENDING(prio),
      .READ_INFO(info), .STRETCH_HOLD_STRAP(strap), .READ_DATA(rd_data),
      .READ_DATA_VALID(valid), .READ_DONE(done), .BUS_FAULT_EXC(exc),
      .SYS_CLK_OUT(sclk), .READ_N(read_n), .ALE(ale), .AD_OUT(ad_out),
      .AD_OE_N(ad_oe_n), .AD_IN(ad_in), .LOW_ADDR(low_addr),
      .BLOCK_READ_N(blk_n), .BUS_RELEASE_EN_N(rel_n), .LANE_EN_N(lane_n),
      .FINAL_DATUM_N(fin_n), .MEM_STROBE_N(mem_n), .IO_STROBE_N_OUT(io_n),
      .IO_STROBE_OE_N(io_oe_n), .IO_STROBE_N_IN(io_pin),
      .EXT_DATA_N_OUT(ext_n), .EXT_DATA_OE_N(ext_oe_n),
      .EXT_DATA_N_IN(ext_pin), .DEBUG_IND(dbg), .READ_CAPTURE_N(cap_n),
      .BUS_FAULT_N(flt_n)
   );

   ext_memory u_ext_memory
   (
      .REF_CLK(clk), .RESETN(rst_n), .READ_N(read_n),
      .BUS_RELEASE_EN_N(rel_n), .LOW_ADDR(low_addr),
      .WAIT_CYCLES(wait_cyc), .FAULT_MODE(fault_mode), .AD_IN(ad_in),
      .READ_CAPTURE_N(cap_n), .BUS_FAULT_N(flt_n)
   );

   task automatic stop_test;
      $display("Counts: run %0d, bad %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic do_reset(input logic s);
      @(posedge clk);
      strap <= s;
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask : do_reset

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask : reg_read

   function automatic rd_port_pkg::read_req_t mk(input logic [31:0] a,
      input logic [3:0] be, input logic [1:0] ps, input logic blk,
      input logic [4:0] tot, input logic big, input logic m);
      mk = '{addr:a, byte_en:be, cache_miss:m, instr_fetch:!m,
             block_read:blk, port_size:ps, big_endian:big, datum_total:tot};
   endfunction : mk

   task automatic do_read(input rd_port_pkg::read_req_t ri,
      input logic [7:0] w, input logic f, input logic st);
      int n;
      @(posedge clk);
      info       <= ri;
      wait_cyc   <= w;
      fault_mode <= f;
      req        <= 1'b1;
      n = 0;
      while (read_n !== 1'b0 && n < 20)
      begin
         @(negedge clk);
         n++;
      end
      check(32'(ale), 32'h1);
      check(32'(sclk), 32'h1);
      check(ad_out, {ri.addr[31:4], ri.byte_en});
      check(32'(rel_n), 32'h1);
      check(32'(dbg), 32'(ri.cache_miss));
      check(32'(blk_n), 32'(!ri.block_read));
      check(32'(fin_n), 32'(ri.datum_total != 5'h1));
      if (!ri.block_read)
         check(32'(low_addr), 32'(ri.addr[3:0]));
      @(posedge clk);
      req <= 1'b0;
      @(negedge clk);
      check(32'(ale), 32'h0);
      check(32'(ad_oe_n), 32'(!st));
      check(32'(rel_n), 32'(st));
      check(32'(dbg), 32'(st ? ri.cache_miss : ri.instr_fetch));
      if (st)
      begin
         @(negedge clk);
         check(32'(ad_oe_n), 32'h1);
         check(32'(rel_n), 32'h0);
         check(32'(dbg), 32'(ri.instr_fetch));
      end
      lanes_seen = lane_n;
      nval = 0;
      nstr = 0;
      io_seen = 1'b0;
      ext_seen = 1'b0;
      exc_seen = 1'b0;
      prev_mem = mem_n;
      n = 0;
      while (done !== 1'b1 && n < 300)
      begin
         @(negedge clk);
         n++;
         if (valid === 1'b1)
            nval++;
         if (prev_mem === 1'b1 && mem_n === 1'b0)
            nstr++;
         prev_mem = mem_n;
         io_seen  = io_seen | (io_pin === 1'b0);
         ext_seen = ext_seen | (ext_pin === 1'b0);
         exc_seen = exc_seen | (exc === 1'b1);
      end
      check(32'(done), 32'h1);
      check(32'(fin_n), 32'h1);
      @(negedge clk);
      check(32'(ext_pin), 32'h1);
   endtask : do_read

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      stop_test();
   end

   initial
   begin
      {rst_n, strap, reg_wr, reg_rd, req, prio, fault_mode} = 7'h0;
      reg_addr = 8'h0;
      wait_cyc = 8'h0;
      reg_wdata = 32'h0;
      info = '0;
      bad_count = 0;
      tests_run = 0;
      do_reset(1'b0);
      reg_read(rd_port_pkg::CTRL_OFFSET, r);
      check(r, 32'h1);
      check(32'(io_oe_n), 32'h1);
      check(32'(ext_oe_n), 32'h1);
      reg_read(8'h20, r);
      check(r, 32'h0);
      reg_write(rd_port_pkg::CTRL_OFFSET, 32'h0000_01ab);
      reg_read(rd_port_pkg::CTRL_OFFSET, r);
      check(r, 32'h0000_01ab);
      check(32'(io_oe_n), 32'h0);
      $display("Test registers done");
      do_read(mk(32'h1234_5678, 4'hf, 2'h0, 1'b0, 5'h1, 1'b0, 1'b1),
              8'h0, 1'b0, 1'b0);
      check(rd_data, 32'h8888_8888);
      check(32'(nval), 32'h1);
      check(32'(nstr), 32'h1);
      check(32'(io_seen), 32'h0);
      check(32'(ext_seen), 32'h1);
      check(32'(lanes_seen), 32'h3);
      do_read(mk(32'h0000_0040, 4'hf, 2'h0, 1'b0, 5'h1, 1'b0, 1'b0),
              8'h6, 1'b0, 1'b0);
      check(32'(io_seen), 32'h1);
      do_read(mk(32'h0000_0200, 4'hf, 2'h2, 1'b1, 5'h10, 1'b0, 1'b0),
              8'h0, 1'b0, 1'b0);
      check(32'(nval), 32'h10);
      check(32'(nstr), 32'h10);
      $display("Test reads done");
      @(posedge clk);
      prio <= 1'b1;
      req  <= 1'b1;
      repeat (6)
      begin
         @(negedge clk);
         check(32'(read_n), 32'h1);
      end
      @(posedge clk);
      prio <= 1'b0;
      req  <= 1'b0;
      do_read(mk(32'h0000_0080, 4'hf, 2'h0, 1'b0, 5'h1, 1'b0, 1'b1),
              8'h2, 1'b1, 1'b0);
      check(32'(exc_seen), 32'h1);
      check(32'(nval), 32'h0);
      $display("Test priority and fault done");
      reg_write(rd_port_pkg::CTRL_OFFSET, 32'h0000_01eb);
      for (int i = 0; i < 3; i++)
      begin
         do_read(mk(32'h0000_0100, lbe[i], 2'h1, 1'b0, 5'h1, lbig[i], 1'b0),
                 8'h0, 1'b0, 1'b0);
         check(32'(lanes_seen), 32'(lexp[i]));
      end
      $display("Test lanes done");
      do_reset(1'b1);
      reg_read(rd_port_pkg::STATUS_OFFSET, r);
      check(r, 32'h2);
      do_read(mk(32'h0000_0300, 4'hf, 2'h0, 1'b0, 5'h1, 1'b0, 1'b1),
              8'h0, 1'b0, 1'b1);
      check(32'(nstr), 32'h0);
      $display("Test stretched hold done");
      stop_test();
   end
endmodule : tb_top
